/* torque_off_defs.svh */
// Register offsets, field positions, reset values and timing counts for torque-off supervision
`ifndef TORQUE_OFF_DEFS_SVH
`define TORQUE_OFF_DEFS_SVH

// ==========================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_TIMING 8'h04
`define OFS_OVL_LIMIT 8'h08
`define OFS_DEV_ALARM 8'h0C
`define OFS_DEV_INFO 8'h10
`define OFS_TEMP 8'h14
`define OFS_IO_SEL 8'h18
`define OFS_STATUS 8'h1C
`define OFS_CLEAR 8'h20

// ==========================================
// Field positions
`define CTRL_ALM_MODE 0
`define CTRL_AUTO_CLR 1
`define CTRL_LED_COND 2
`define CTRL_IO_INV 3
`define CTRL_CLR_ACT 5:4
`define CTRL_FR_ACT 7:6
`define CTRL_EX_ACT 9:8
`define CTRL_STOP_ACT 11:10
`define TIM_DUAL 6:0
`define TIM_BLANK 22:16
`define TEMP_DRV 7:0
`define TEMP_MTR 15:8
`define CLR_ALARMS 0
`define CLR_INFO 1

// ==========================================
// Reset values and setting codes
`define CTRL_RESET 32'h0000_0416
`define TIMING_RESET 32'h0000_0000
`define OVL_LIMIT_RESET 9'h032
`define DEV_ALARM_RESET 15'h012C
`define DEV_INFO_RESET 15'h012C
`define TEMP_RESET 16'h5555
`define IO_SEL_RESET 8'h80
`define ACT_EDGE 2'h1
`define ACT_LEVEL 2'h2
`define ACT_ENABLE 2'h2
`define DUAL_OFF_MAX 7'h0A
`define IO_SIGNALS 128

// ==========================================
// Timing
`define CLK_PERIOD_NS 10
`define MS_TIME_NS 1000000
`define MS_CYCLES (`MS_TIME_NS / `CLK_PERIOD_NS)
`define TENTH_MS 7'h63
`define LED_HALF_MS 8'hF9

`endif

/* torque_off_pkg.sv */
// Types shared by the torque-off supervision block
package torque_off_pkg;
	typedef enum logic [1:0] {
		TORQUE_RUN,
		TORQUE_OFF,
		TORQUE_BLANK,
		TORQUE_WAIT
	} torque_state_type;
endpackage

/* pin_sync.sv */
// Two-stage synchroniser for asynchronous input pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] stage_reg;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_reg <= '0;
			synced <= '0;
		end else begin
			stage_reg <= pin;
			synced <= stage_reg;
		end
	end
endmodule

/* torque_off_alarm_info.sv */
// Safe-torque-off supervision, alarm thresholds and information outputs with APB registers
`timescale 1ns/1ps
`include "torque_off_defs.svh"
module torque_off_alarm_info import torque_off_pkg::*; #(
	parameter int MS_CYCLES = `MS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic safe_off_in_a,
	input wire logic safe_off_in_b,
	input wire logic torque_off_clear_in,
	input wire logic fault_reset_in,
	input wire logic excite_on_in,
	input wire logic stop_in,
	input wire logic overload_in,
	input wire logic [15:0] pos_dev,
	input wire logic [7:0] drv_temp,
	input wire logic [7:0] motor_temp,
	input wire logic [127:0] user_io_signals,
	output logic motor_excite,
	output logic ext_torque_off_state,
	output logic alarm_out,
	output logic info_out,
	output logic led_out,
	output logic pos_dev_notice,
	output logic drv_temp_notice,
	output logic motor_temp_notice,
	output logic user_io_watch_notice
);
	// ==========================================
	// Pin synchronisers
	logic [6:0] pins;
	logic on_a, on_b, clr_in, fr_in, ex_in, stop_s, ovl_in;
	pin_sync #(.WIDTH(7)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin({safe_off_in_a, safe_off_in_b, torque_off_clear_in, fault_reset_in,
			excite_on_in, stop_in, overload_in}),
		.synced(pins)
	);
	assign {on_a, on_b, clr_in, fr_in, ex_in, stop_s, ovl_in} = pins;

	function automatic logic rose(input logic now, input logic was);
		return now & ~was;
	endfunction

	// ==========================================
	// APB slave and configuration
	logic [31:0] ctrl_reg, ctrl_next, timing_reg, timing_next;
	logic [8:0] ovl_limit_reg, ovl_limit_next;
	logic [14:0] dev_alarm_reg, dev_alarm_next, dev_info_reg, dev_info_next;
	logic [15:0] temp_reg, temp_next;
	logic [7:0] io_sel_reg, io_sel_next;
	logic [31:0] prdata_next, status;
	logic pready_next, pslverr_next, access, wr_en, mapped, clr_alarms, clr_info;

	assign access = psel & penable & pready;
	assign wr_en = access & pwrite;
	assign clr_alarms = wr_en && paddr == `OFS_CLEAR && pwdata[`CLR_ALARMS];
	assign clr_info = wr_en && paddr == `OFS_CLEAR && pwdata[`CLR_INFO];

	// Decode, write and read data; one wait state per access
	always_comb begin
		ctrl_next = ctrl_reg;
		timing_next = timing_reg;
		ovl_limit_next = ovl_limit_reg;
		dev_alarm_next = dev_alarm_reg;
		dev_info_next = dev_info_reg;
		temp_next = temp_reg;
		io_sel_next = io_sel_reg;
		mapped = 1'b1;
		prdata_next = 32'h0000_0000;
		case (paddr)
			`OFS_CTRL: prdata_next = {20'h00000, ctrl_reg[11:0]};
			`OFS_TIMING: prdata_next = {9'h000, timing_reg[22:16], 9'h000, timing_reg[6:0]};
			`OFS_OVL_LIMIT: prdata_next = {23'h000000, ovl_limit_reg};
			`OFS_DEV_ALARM: prdata_next = {17'h00000, dev_alarm_reg};
			`OFS_DEV_INFO: prdata_next = {17'h00000, dev_info_reg};
			`OFS_TEMP: prdata_next = {16'h0000, temp_reg};
			`OFS_IO_SEL: prdata_next = {24'h000000, io_sel_reg};
			`OFS_STATUS: prdata_next = status;
			`OFS_CLEAR: prdata_next = 32'h0000_0000;
			default: mapped = 1'b0;
		endcase
		if (wr_en) begin
			case (paddr)
				`OFS_CTRL: ctrl_next = {20'h00000, pwdata[11:0]};
				`OFS_TIMING: timing_next = {9'h000, pwdata[22:16], 9'h000, pwdata[6:0]};
				`OFS_OVL_LIMIT: ovl_limit_next = pwdata[8:0];
				`OFS_DEV_ALARM: dev_alarm_next = pwdata[14:0];
				`OFS_DEV_INFO: dev_info_next = pwdata[14:0];
				`OFS_TEMP: temp_next = pwdata[15:0];
				`OFS_IO_SEL: io_sel_next = pwdata[7:0];
				default: ;
			endcase
		end
		pready_next = psel & penable & ~pready;
		pslverr_next = pready_next & ~mapped;
		if (!pready_next) begin
			prdata_next = 32'h0000_0000;
		end
	end

	// Bus and configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `CTRL_RESET;
			timing_reg <= `TIMING_RESET;
			ovl_limit_reg <= `OVL_LIMIT_RESET;
			dev_alarm_reg <= `DEV_ALARM_RESET;
			dev_info_reg <= `DEV_INFO_RESET;
			temp_reg <= `TEMP_RESET;
			io_sel_reg <= `IO_SEL_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			timing_reg <= timing_next;
			ovl_limit_reg <= ovl_limit_next;
			dev_alarm_reg <= dev_alarm_next;
			dev_info_reg <= dev_info_next;
			temp_reg <= temp_next;
			io_sel_reg <= io_sel_next;
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
		end
	end

	// ==========================================
	// Time base: millisecond, tenth-second and LED ticks
	logic [16:0] ms_cnt_reg, ms_cnt_next;
	logic [6:0] tenth_cnt_reg, tenth_cnt_next;
	logic [7:0] led_cnt_reg, led_cnt_next;
	logic ms_tick, tenth_tick, blink_reg, blink_next;

	assign ms_tick = ms_cnt_reg == 17'(MS_CYCLES - 1);
	assign tenth_tick = ms_tick && tenth_cnt_reg == `TENTH_MS;

	// Divider chain
	always_comb begin
		ms_cnt_next = ms_tick ? 17'h00000 : ms_cnt_reg + 17'h00001;
		tenth_cnt_next = tenth_cnt_reg;
		led_cnt_next = led_cnt_reg;
		blink_next = blink_reg;
		if (ms_tick) begin
			tenth_cnt_next = tenth_tick ? 7'h00 : tenth_cnt_reg + 7'h01;
			led_cnt_next = led_cnt_reg == `LED_HALF_MS ? 8'h00 : led_cnt_reg + 8'h01;
			blink_next = blink_reg ^ (led_cnt_reg == `LED_HALF_MS);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_reg <= 17'h00000;
			tenth_cnt_reg <= 7'h00;
			led_cnt_reg <= 8'h00;
			blink_reg <= 1'b0;
		end else begin
			ms_cnt_reg <= ms_cnt_next;
			tenth_cnt_reg <= tenth_cnt_next;
			led_cnt_reg <= led_cnt_next;
			blink_reg <= blink_next;
		end
	end

	// ==========================================
	// Safe-off supervision and re-excitation
	torque_state_type state_reg, state_next;
	logic [6:0] dual_cnt_reg, dual_cnt_next, blank_reg, blank_next;
	logic [8:0] ovl_cnt_reg, ovl_cnt_next;
	logic [3:0] alm_reg, alm_next;
	logic [3:0] prev_reg;
	logic both_on, any_off, alarm_any, path, excite_next;

	assign both_on = on_a & on_b;
	assign any_off = ~both_on;
	assign alarm_any = |alm_reg;

	// Enabled re-excitation paths
	always_comb begin
		path = 1'b0;
		if (ctrl_reg[`CTRL_CLR_ACT] == `ACT_EDGE && rose(clr_in, prev_reg[3])) path = 1'b1;
		if (ctrl_reg[`CTRL_CLR_ACT] == `ACT_LEVEL && clr_in) path = 1'b1;
		if (ctrl_reg[`CTRL_FR_ACT] == `ACT_ENABLE && rose(fr_in, prev_reg[2])) path = 1'b1;
		if (ctrl_reg[`CTRL_EX_ACT] == `ACT_ENABLE && rose(ex_in, prev_reg[1])) path = 1'b1;
		if (ctrl_reg[`CTRL_STOP_ACT] == `ACT_ENABLE && rose(stop_s, prev_reg[0])) path = 1'b1;
	end

	// State, timers and sticky alarms; a new cause wins over a clear
	always_comb begin
		state_next = state_reg;
		blank_next = blank_reg;
		case (state_reg)
			TORQUE_RUN: if (any_off) state_next = TORQUE_OFF;
			TORQUE_OFF: begin
				if (both_on) begin
					state_next = TORQUE_BLANK;
					blank_next = timing_reg[`TIM_BLANK];
				end
			end
			TORQUE_BLANK: begin
				if (any_off) state_next = TORQUE_OFF;
				else if (blank_reg == 7'h00) state_next = TORQUE_WAIT;
				else if (ms_tick) blank_next = blank_reg - 7'h01;
			end
			TORQUE_WAIT: begin
				if (any_off) state_next = TORQUE_OFF;
				else if (path && !alarm_any) state_next = TORQUE_RUN;
			end
			default: state_next = TORQUE_OFF;
		endcase
		excite_next = state_next == TORQUE_RUN;
		dual_cnt_next = 7'h00;
		if (on_a ^ on_b) begin
			dual_cnt_next = dual_cnt_reg;
			if (ms_tick && dual_cnt_reg != 7'h7F) dual_cnt_next = dual_cnt_reg + 7'h01;
		end
		ovl_cnt_next = 9'h000;
		if (ovl_in) begin
			ovl_cnt_next = ovl_cnt_reg;
			if (tenth_tick && ovl_cnt_reg != 9'h1FF) ovl_cnt_next = ovl_cnt_reg + 9'h001;
		end
		alm_next = clr_alarms ? 4'h0 : alm_reg;
		if (ctrl_reg[`CTRL_ALM_MODE] && any_off) alm_next[0] = 1'b1;
		if (timing_reg[`TIM_DUAL] > `DUAL_OFF_MAX && dual_cnt_reg > timing_reg[`TIM_DUAL])
			alm_next[1] = 1'b1;
		if (ovl_cnt_reg >= ovl_limit_reg) alm_next[2] = 1'b1;
		if ({1'b0, pos_dev} > {2'b00, dev_alarm_reg}) alm_next[3] = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= TORQUE_OFF;
			blank_reg <= 7'h00;
			dual_cnt_reg <= 7'h00;
			ovl_cnt_reg <= 9'h000;
			alm_reg <= 4'h0;
			prev_reg <= 4'h0;
			motor_excite <= 1'b0;
			ext_torque_off_state <= 1'b1;
			alarm_out <= 1'b0;
		end else begin
			state_reg <= state_next;
			blank_reg <= blank_next;
			dual_cnt_reg <= dual_cnt_next;
			ovl_cnt_reg <= ovl_cnt_next;
			alm_reg <= alm_next;
			prev_reg <= {clr_in, fr_in, ex_in, stop_s};
			motor_excite <= excite_next;
			ext_torque_off_state <= ~excite_next;
			alarm_out <= |alm_next;
		end
	end

	// ==========================================
	// Information notices, output and LED
	logic [3:0] cause, info_next;
	logic led_next;

	// Latch notices; auto-clear lets them follow the cause
	always_comb begin
		cause[0] = {1'b0, pos_dev} > {2'b00, dev_info_reg};
		cause[1] = drv_temp >= temp_reg[`TEMP_DRV];
		cause[2] = motor_temp >= temp_reg[`TEMP_MTR];
		cause[3] = (io_sel_reg[7] ? 1'b0 : user_io_signals[io_sel_reg[6:0]])
			^ ctrl_reg[`CTRL_IO_INV];
		info_next = {user_io_watch_notice, motor_temp_notice, drv_temp_notice, pos_dev_notice};
		if (ctrl_reg[`CTRL_AUTO_CLR] || clr_info) info_next = 4'h0;
		info_next = info_next | cause;
		led_next = (|info_next && ctrl_reg[`CTRL_LED_COND]) ? blink_reg : 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_dev_notice <= 1'b0;
			drv_temp_notice <= 1'b0;
			motor_temp_notice <= 1'b0;
			user_io_watch_notice <= 1'b0;
			info_out <= 1'b0;
			led_out <= 1'b1;
		end else begin
			{user_io_watch_notice, motor_temp_notice, drv_temp_notice, pos_dev_notice} <= info_next;
			info_out <= |info_next;
			led_out <= led_next;
		end
	end

	assign status = {20'h00000, blink_reg, info_out, user_io_watch_notice, motor_temp_notice,
		drv_temp_notice, pos_dev_notice, alm_reg, motor_excite, ext_torque_off_state};

	// ==========================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	alarm_mode_a: assert property (ctrl_reg[0] && any_off |=> alm_reg[0] && alarm_out)
		else $error("safe-off alarm not raised");
	dual_check_a: assert property (timing_reg[6:0] <= 7'h0A && !alm_reg[1] && !clr_alarms
		|=> !alm_reg[1] || $past(timing_reg[6:0]) > 7'h0A)
		else $error("dual check fired while disabled");
	blank_hold_a: assert property (state_reg == TORQUE_BLANK |=> !motor_excite)
		else $error("excited during blanking");
	clear_edge_a: assert property (state_reg == TORQUE_WAIT && both_on && !alarm_any
		&& ctrl_reg[5:4] == 2'h1 && clr_in && !prev_reg[3] |=> motor_excite)
		else $error("clear edge did not excite");
	fault_path_a: assert property (state_reg == TORQUE_WAIT && ctrl_reg[7:6] != 2'h2
		&& ctrl_reg[5:4] == 2'h1 && !rose(clr_in, prev_reg[3]) && ctrl_reg[9:8] != 2'h2
		&& ctrl_reg[11:10] != 2'h2 |=> !motor_excite)
		else $error("disabled path excited");
	off_deexcite_a: assert property (any_off |=> !motor_excite ##1 !motor_excite)
		else $error("excited with safe input off");
	overload_a: assert property (ovl_cnt_reg >= ovl_limit_reg |=> alm_reg[2])
		else $error("overload alarm missing");
	deviation_a: assert property ({1'b0, pos_dev} > {2'b00, dev_alarm_reg} |=> alm_reg[3])
		else $error("deviation alarm missing");
	info_hold_a: assert property (!ctrl_reg[1] && pos_dev_notice && !clr_info
		|=> pos_dev_notice)
		else $error("notice dropped without auto-clear");
	led_steady_a: assert property (!ctrl_reg[2] |=> led_out)
		else $error("LED blinked while disabled");
	user_io_a: assert property (ctrl_reg[1] && io_sel_reg[7] && !clr_info
		|=> user_io_watch_notice == $past(ctrl_reg[3]))
		else $error("constant-off signal not honoured");
	temp_a: assert property (drv_temp >= temp_reg[7:0] |=> drv_temp_notice && info_out)
		else $error("driver temperature notice missing");

	reexcite_c: cover property (state_reg == TORQUE_WAIT ##1 state_reg == TORQUE_RUN);
	blank_c: cover property (state_reg == TORQUE_BLANK && blank_reg != 7'h00);
	dual_c: cover property (!alm_reg[1] ##1 alm_reg[1]);
endmodule

/* safe_host.sv */
// Behavioural safety circuit and host controller driving the supervision pins
`timescale 1ns/1ps
module safe_host (
	input wire logic pclk,
	output logic safe_a,
	output logic safe_b,
	output logic [3:0] pins
);
	// ==========================================
	// Pins start off
	initial begin
		safe_a = 1'h0;
		safe_b = 1'h0;
		pins = 4'h0;
	end

	// Safe-off pair changes just after a rising edge
	task automatic set_safe(input logic a, input logic b);
		@(posedge pclk);
		safe_a <= a;
		safe_b <= b;
	endtask

	// Pin order: clear, fault reset, excite on, stop
	task automatic set_pin(input int i, input logic v);
		@(posedge pclk);
		pins[i] <= v;
	endtask
endmodule

/* torque_off_alarm_info_tb.sv */
// Self-checking bench for the torque-off supervision block
`timescale 1ns/1ps
`include "torque_off_defs.svh"
module torque_off_alarm_info_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, led_q;
	logic [7:0] paddr, drv_temp, motor_temp;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] pos_dev;
	logic [127:0] usr;
	logic overload_in, motor_excite, ext_state, alarm_out, info_out, led_out;
	logic pdn, dtn, mtn, uwn, sa, sb;
	logic [3:0] pins, e;
	int n_fail, num_checks, toggles;
	localparam logic [7:0] ofs_list [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	localparam logic [31:0] rst_list [7] = '{32'h416, 32'h0, 32'h32, 32'h12C, 32'h12C,
		32'h5555, 32'h80};

	safe_host i_safe_host (.pclk(pclk), .safe_a(sa), .safe_b(sb), .pins(pins));

	torque_off_alarm_info #(.MS_CYCLES(10)) i_torque_off_alarm_info (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.safe_off_in_a(sa), .safe_off_in_b(sb), .torque_off_clear_in(pins[0]),
		.fault_reset_in(pins[1]), .excite_on_in(pins[2]), .stop_in(pins[3]),
		.overload_in(overload_in), .pos_dev(pos_dev), .drv_temp(drv_temp),
		.motor_temp(motor_temp), .user_io_signals(usr), .motor_excite(motor_excite),
		.ext_torque_off_state(ext_state), .alarm_out(alarm_out), .info_out(info_out),
		.led_out(led_out), .pos_dev_notice(pdn), .drv_temp_notice(dtn),
		.motor_temp_notice(mtn), .user_io_watch_notice(uwn));

	// ==========================================
	// Clock and LED change counter
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (led_out !== led_q) toggles++;
		led_q <= led_out;
	end

	// ==========================================
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) begin
			n_fail++;
			end_of_test();
		end
	endtask
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			n_fail++;
			$display("mismatch %s exp %0h got %0h", s, x, g);
		end
	endtask
	task automatic safe(input logic a, input logic b);
		i_safe_host.set_safe(a, b);
		cyc(6);
	endtask
	task automatic pin(input int i, input logic v);
		i_safe_host.set_pin(i, v);
		cyc(6);
	endtask
	task automatic pulse();
		pin(0, 1'h1);
		pin(0, 1'h0);
	endtask
	// Control word: clear on edge, other paths off, one path set
	function automatic logic [31:0] ctrl_for(int p, int v);
		logic [31:0] c;
		c = 32'h556;
		c[2*p+4 +: 2] = v[1:0];
		return c;
	endfunction
	function automatic logic [3:0] exp_notes(int pd, int tp, int dt, int td, int mt, int tm,
		logic io);
		return {pd > tp, dt >= td, mt >= tm, io};
	endfunction
	task automatic end_of_test();
		if (n_fail == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#500000;
		n_fail++;
		end_of_test();
	end

	// ==========================================
	// Main sequence
	initial begin
		int td, tm, tv, sel, inv;
		{psel, penable, pwrite, overload_in, presetn} = 5'h0;
		{paddr, pwdata, pos_dev, drv_temp, motor_temp} = '0;
		usr = '1;
		{n_fail, num_checks, toggles} = '0;
		void'($urandom(32'hA0A0F43F));
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		cyc(4);
		for (int i = 0; i < 7; i++) begin
			apb(1'h0, ofs_list[i], 32'h0);
			chk("reset value", rst_list[i], q);
		end
		apb(1'h0, 8'h40, 32'h0);
		chk("unmapped err", 1, err);
		chk("io notice", 0, uwn);
		chk("excite", 0, motor_excite);
		chk("torque off", 1, ext_state);
		safe(1'h1, 1'h1);
		chk("excite", 0, motor_excite);
		pulse();
		chk("excite", 1, motor_excite);
		chk("torque off", 0, ext_state);
		safe(1'h0, 1'h1);
		chk("excite", 0, motor_excite);
		chk("alarm", 0, alarm_out);
		// Alarm mode 1 blocks re-excitation until cleared
		apb(1'h1, `OFS_CTRL, 32'h557);
		safe(1'h1, 1'h1);
		safe(1'h1, 1'h0);
		chk("alarm", 1, alarm_out);
		safe(1'h1, 1'h1);
		pulse();
		chk("excite", 0, motor_excite);
		apb(1'h1, `OFS_CLEAR, 32'h1);
		pulse();
		chk("excite", 1, motor_excite);
		// Each path in both settings: pin held before, then a fresh edge
		for (int p = 0; p < 4; p++) begin
			for (int v = 1; v < 3; v++) begin
				apb(1'h1, `OFS_CTRL, ctrl_for(p, v));
				safe(1'h0, 1'h0);
				pin(p, 1'h1);
				safe(1'h1, 1'h1);
				chk("level excite", p == 0 && v == 2, motor_excite);
				pin(p, 1'h0);
				pin(p, 1'h1);
				chk("edge excite", p == 0 || v == 2, motor_excite);
				pin(p, 1'h0);
			end
		end
		// Blanking of 5 ms hides an early clear edge
		apb(1'h1, `OFS_CTRL, 32'h556);
		apb(1'h1, `OFS_TIMING, 32'h50000);
		safe(1'h0, 1'h0);
		safe(1'h1, 1'h1);
		pulse();
		chk("blank excite", 0, motor_excite);
		cyc(60);
		pulse();
		chk("blank excite", 1, motor_excite);
		// Dual check off at 10 ms, active at 15 ms
		for (int d = 10; d < 16; d += 5) begin
			apb(1'h1, `OFS_TIMING, d);
			safe(1'h1, 1'h1);
			safe(1'h0, 1'h1);
			cyc(100);
			chk("dual alarm", 0, alarm_out);
			cyc(150);
			chk("dual alarm", d > 10, alarm_out);
			safe(1'h0, 1'h0);
			apb(1'h1, `OFS_CLEAR, 32'h1);
		end
		// Overload limit of three tenths of a second
		apb(1'h1, `OFS_OVL_LIMIT, 32'h3);
		overload_in <= 1'h1;
		cyc(1500);
		chk("overload alarm", 0, alarm_out);
		cyc(2500);
		chk("overload alarm", 1, alarm_out);
		overload_in <= 1'h0;
		apb(1'h1, `OFS_CLEAR, 32'h1);
		// Deviation alarm only above its limit
		tv = 1 + $urandom % 29999;
		apb(1'h1, `OFS_DEV_ALARM, tv);
		pos_dev <= 16'(tv);
		cyc(4);
		chk("dev alarm", 0, alarm_out);
		pos_dev <= 16'(tv + 1);
		cyc(4);
		chk("dev alarm", 1, alarm_out);
		pos_dev <= 16'h0;
		apb(1'h1, `OFS_DEV_ALARM, 32'h7530);
		apb(1'h1, `OFS_CLEAR, 32'h1);
		// Random thresholds around the measurements, random watched signal
		for (int i = 0; i < 24; i++) begin
			td = 40 + $urandom % 46;
			tm = 40 + $urandom % 81;
			tv = 1 + $urandom % 29998;
			sel = $urandom % 128;
			inv = $urandom % 2;
			apb(1'h1, `OFS_TEMP, {tm[7:0], td[7:0]});
			apb(1'h1, `OFS_DEV_INFO, tv);
			apb(1'h1, `OFS_IO_SEL, sel);
			apb(1'h1, `OFS_CTRL, 32'h556 | 32'(inv << 3));
			drv_temp <= 8'(td - 1 + $urandom % 3);
			motor_temp <= 8'(tm - 1 + $urandom % 3);
			pos_dev <= 16'(tv - 1 + $urandom % 3);
			usr <= {$urandom, $urandom, $urandom, $urandom};
			cyc(4);
			e = exp_notes(pos_dev, tv, drv_temp, td, motor_temp, tm, usr[sel] ^ inv[0]);
			chk("pos notice", e[3], pdn);
			chk("drv notice", e[2], dtn);
			chk("mtr notice", e[1], mtn);
			chk("io notice", e[0], uwn);
			chk("info", |e, info_out);
		end
		// Held notice without auto clear, LED blinking then steady
		apb(1'h1, `OFS_CTRL, 32'h554);
		{usr, pos_dev, motor_temp} <= '0;
		drv_temp <= 8'hFF;
		cyc(4);
		drv_temp <= 8'h0;
		cyc(4);
		chk("held notice", 1, dtn);
		chk("held info", 1, info_out);
		toggles = 0;
		cyc(6000);
		chk("blinking", 1, toggles > 1 && toggles < 4);
		apb(1'h1, `OFS_CTRL, 32'h550);
		cyc(10);
		toggles = 0;
		cyc(3000);
		chk("blinking", 0, toggles);
		chk("led", 1, led_out);
		apb(1'h1, `OFS_CLEAR, 32'h2);
		cyc(4);
		chk("info", 0, info_out);
		end_of_test();
	end
endmodule
